// ---- acsc_top.sv ----
// Notes on behaviour
// R1: regular start sets status bit 4; writing 0 clears, 1 leaves it.
// R2: injected start sets status bit 3; writing 0 clears, 1 leaves it.
// R3: injected group end sets bit 2 after all injected channels; write 0 clears.
// R4: end of regular or injected group sets conversion-end bit 1.
// R5: bit 1 clears on write 0 or on reading the regular result.
// R6: value outside threshold window sets bit 0; only writing 0 clears.
// R7: calibration voltage bits 26:25, 01 half, 10 three quarters, reset 01.
// R8: bit 23 enables watchdog on regular conversions.
// R9: bit 22 enables watchdog on injected conversions.
// R10: bits 15:13 give channels per trigger, code plus one.
// R11: bit 12 puts injected group in discontinuous mode.
// R12: bit 11 puts regular group in discontinuous mode.
// R13: bit 10 starts injected group automatically after regular group.
// R14: software disables injected external trigger before enabling auto switch.
// R15: single-channel bit limits watchdog to the selected channel.
// R16: software never combines auto switch with discontinuous, nor both groups.
// R17: reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module acsc_top (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // write address
  input  wire logic [acsc_pkg::ACSC_AW-1:0] awaddr,
  input  wire logic [2:0]                  awprot,
  input  wire logic                        awvalid,
  output var  logic                        awready,
  // write data
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output var  logic                        wready,
  // write response
  output var  logic [1:0]                  bresp,
  output var  logic                        bvalid,
  input  wire logic                        bready,
  // read address
  input  wire logic [acsc_pkg::ACSC_AW-1:0] araddr,
  input  wire logic [2:0]                  arprot,
  input  wire logic                        arvalid,
  output var  logic                        arready,
  // read data
  output var  logic [31:0]                 rdata,
  output var  logic [1:0]                  rresp,
  output var  logic                        rvalid,
  input  wire logic                        rready,
  // sequencer events
  input  wire logic                        seq_reg_start,
  input  wire logic                        seq_inj_start,
  input  wire logic                        seq_reg_done,
  input  wire logic                        seq_inj_done,
  // converted samples
  input  wire logic                        conv_valid,
  input  wire logic                        conv_injected,
  input  wire logic [4:0]                  conv_channel,
  input  wire logic [acsc_pkg::ACSC_VW-1:0] conv_value,
  // regular result
  input  wire logic [acsc_pkg::ACSC_VW-1:0] result_data,
  // control to sequencer and analog core
  output var  logic [1:0]                  calibration_voltage_select,
  output var  logic                        calibration_voltage_valid,
  output var  logic [2:0]                  discontinuous_length,
  output var  logic [3:0]                  disc_channel_count,
  output var  logic                        regular_discontinuous_enable,
  output var  logic                        injected_discontinuous_enable,
  output var  logic                        auto_injected_switch,
  // interrupt
  output var  logic                        irq
);

  import acsc_pkg::*;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic               awready_q, awready_d;
  logic               wready_q, wready_d;
  logic               bvalid_q, bvalid_d;
  logic [1:0]         bresp_q;
  logic               arready_q, arready_d;
  logic               rvalid_q, rvalid_d;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;
  logic               aw_have_q, aw_have_d;
  logic               w_have_q, w_have_d;
  logic [ACSC_AW-1:0] aw_addr_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;

  // ----------------------------------------------------------------
  // block state
  // ----------------------------------------------------------------
  logic [31:0]         ctrl_q, ctrl_d;
  logic [ACSC_VW-1:0]  wd_high_q, wd_high_d;
  logic [ACSC_VW-1:0]  wd_low_q, wd_low_d;
  logic [4:0]          mask_q, mask_d;
  logic [3:0]          dcnt_q;
  logic                cal_ok_q;
  logic                irq_q;
  logic [ACSC_NFLAG-1:0] flag_q;
  logic [ACSC_NFLAG-1:0] irq_flag_q;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  wire aw_fire  = awvalid & awready_q;
  wire w_fire   = wvalid & wready_q;
  wire ar_fire  = arvalid & arready_q;
  // one write at a time: each half held until both are present and no response is pending
  wire do_write = aw_have_q & w_have_q & ~bvalid_q;

  assign aw_have_d = aw_have_q ? ~do_write : aw_fire;
  assign w_have_d  = w_have_q ? ~do_write : w_fire;
  assign bvalid_d  = bvalid_q ? ~bready : do_write;
  assign awready_d = ~aw_have_d & ~bvalid_d;
  assign wready_d  = ~w_have_d & ~bvalid_d;
  assign rvalid_d  = rvalid_q ? ~rready : ar_fire;
  assign arready_d = ~rvalid_d;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire ws_stat = aw_addr_q == ACSC_OFF_STAT;
  wire ws_ctrl = aw_addr_q == ACSC_OFF_CTRL;
  wire ws_hi   = aw_addr_q == ACSC_OFF_WDHI;
  wire ws_lo   = aw_addr_q == ACSC_OFF_WDLO;
  wire ws_res  = aw_addr_q == ACSC_OFF_RES;
  wire ws_irq  = aw_addr_q == ACSC_OFF_IRQ;
  wire ws_mask = aw_addr_q == ACSC_OFF_MASK;
  wire ws_hit  = ws_stat | ws_ctrl | ws_hi | ws_lo | ws_res | ws_irq | ws_mask;

  wire do_stat = do_write & ws_stat;
  wire do_ctrl = do_write & ws_ctrl;

  wire [31:0] wr_lanes = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                          {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // reserved control bits never store anything
  assign ctrl_d = do_ctrl ?
                  (((ctrl_q & ~wr_lanes) | (w_data_q & wr_lanes)) & ACSC_CTRL_MASK) :
                  ctrl_q; // R17

  assign wd_high_d = (do_write & ws_hi) ?
                     {w_strb_q[1] ? w_data_q[9:8] : wd_high_q[9:8],
                      w_strb_q[0] ? w_data_q[7:0] : wd_high_q[7:0]} : wd_high_q;
  assign wd_low_d  = (do_write & ws_lo) ?
                     {w_strb_q[1] ? w_data_q[9:8] : wd_low_q[9:8],
                      w_strb_q[0] ? w_data_q[7:0] : wd_low_q[7:0]} : wd_low_q;
  assign mask_d    = (do_write & ws_mask & w_strb_q[0]) ? w_data_q[4:0] : mask_q;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire [1:0] c_cal    = ctrl_q[ACSC_C_CAL_LSB +: 2];
  wire       c_reg_wd = ctrl_q[ACSC_C_REG_WD];
  wire       c_inj_wd = ctrl_q[ACSC_C_INJ_WD];
  wire [2:0] c_dlen   = ctrl_q[ACSC_C_DLEN_LSB +: 3];
  wire       c_wd_sgl = ctrl_q[ACSC_C_WD_SGL];
  wire [4:0] c_wd_ch  = ctrl_q[ACSC_C_WD_CH +: 5];

  // ----------------------------------------------------------------
  // analog watchdog
  // ----------------------------------------------------------------
  wire wd_grp_ok = conv_injected ? c_inj_wd : c_reg_wd; // R8 R9
  wire wd_ch_ok  = ~c_wd_sgl | (conv_channel == c_wd_ch); // R15
  wire wd_out    = (conv_value > wd_high_q) | (conv_value < wd_low_q);
  wire wd_hit    = conv_valid & wd_grp_ok & wd_ch_ok & wd_out; // R6

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire rs_stat = araddr == ACSC_OFF_STAT;
  wire rs_ctrl = araddr == ACSC_OFF_CTRL;
  wire rs_hi   = araddr == ACSC_OFF_WDHI;
  wire rs_lo   = araddr == ACSC_OFF_WDLO;
  wire rs_res  = araddr == ACSC_OFF_RES;
  wire rs_irq  = araddr == ACSC_OFF_IRQ;
  wire rs_mask = araddr == ACSC_OFF_MASK;
  wire rs_hit  = rs_stat | rs_ctrl | rs_hi | rs_lo | rs_res | rs_irq | rs_mask;

  wire res_rd  = ar_fire & rs_res;
  wire irq_rd  = ar_fire & rs_irq;

  wire [31:0] rd_word =
      ({32{rs_stat}} & {27'h0000000, flag_q}) |
      ({32{rs_ctrl}} & ctrl_q) |
      ({32{rs_hi}}   & {22'h000000, wd_high_q}) |
      ({32{rs_lo}}   & {22'h000000, wd_low_q}) |
      ({32{rs_res}}  & {22'h000000, result_data}) |
      ({32{rs_irq}}  & {27'h0000000, irq_flag_q}) |
      ({32{rs_mask}} & {27'h0000000, mask_q}); // R17

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  wire [ACSC_NFLAG-1:0] ev;
  wire [ACSC_NFLAG-1:0] stat_clr;

  assign ev[ACSC_F_REG_START] = seq_reg_start; // R1
  assign ev[ACSC_F_INJ_START] = seq_inj_start; // R2
  assign ev[ACSC_F_INJ_END]   = seq_inj_done; // R3
  assign ev[ACSC_F_CONV_END]  = seq_reg_done | seq_inj_done; // R4
  assign ev[ACSC_F_WD]        = wd_hit; // R6

  // a written 1 leaves a flag alone; only a 0 in lane 0, or for bit 1 a result read, clears
  assign stat_clr[ACSC_F_REG_START] = do_stat & w_strb_q[0] & ~w_data_q[4]; // R1
  assign stat_clr[ACSC_F_INJ_START] = do_stat & w_strb_q[0] & ~w_data_q[3]; // R2
  assign stat_clr[ACSC_F_INJ_END]   = do_stat & w_strb_q[0] & ~w_data_q[2]; // R3
  assign stat_clr[ACSC_F_CONV_END]  = (do_stat & w_strb_q[0] & ~w_data_q[1]) | res_rd; // R5
  assign stat_clr[ACSC_F_WD]        = do_stat & w_strb_q[0] & ~w_data_q[0]; // R6

  genvar gi;
  generate
    for (gi = 0; gi < ACSC_NFLAG; gi++) begin : g_flag
      acsc_sticky u_stat (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (ev[gi]),
        .clr     (stat_clr[gi]),
        .flag_q  (flag_q[gi])
      );
      // interrupt copy is cleared by reading it, so polling status stays undisturbed
      acsc_sticky u_irq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (ev[gi]),
        .clr     (irq_rd),
        .flag_q  (irq_flag_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bresp_q   <= ACSC_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= ACSC_RESP_OKAY;
    end else begin
      if (aw_fire) aw_addr_q <= awaddr;
      if (w_fire) w_data_q <= wdata;
      if (w_fire) w_strb_q <= wstrb;
      if (do_write) bresp_q <= ws_hit ? ACSC_RESP_OKAY : ACSC_RESP_DECERR;
      if (ar_fire) rdata_q <= rd_word;
      if (ar_fire) rresp_q <= rs_hit ? ACSC_RESP_OKAY : ACSC_RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= ACSC_CTRL_RST; // R7
      wd_high_q <= ACSC_THR_RST;
      wd_low_q  <= ACSC_THR_RST;
      mask_q    <= ACSC_MASK_RST;
      dcnt_q    <= ACSC_DCNT_RST;
      cal_ok_q  <= 1'b1;
      irq_q     <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      wd_high_q <= wd_high_d;
      wd_low_q  <= wd_low_d;
      mask_q    <= mask_d;
      dcnt_q    <= {1'b0, c_dlen} + 4'h1; // R10
      cal_ok_q  <= (c_cal == ACSC_CAL_HALF) | (c_cal == ACSC_CAL_3Q); // R7
      irq_q     <= |(irq_flag_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  assign calibration_voltage_select    = c_cal; // R7
  assign calibration_voltage_valid     = cal_ok_q;
  assign discontinuous_length          = c_dlen;
  assign disc_channel_count            = dcnt_q;
  assign injected_discontinuous_enable = ctrl_q[ACSC_C_INJ_DISC]; // R11
  assign regular_discontinuous_enable  = ctrl_q[ACSC_C_REG_DISC]; // R12
  // sequencer must also see its injected external trigger off
  assign auto_injected_switch          = ctrl_q[ACSC_C_AUTO]; // R13
  assign irq                           = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reg_start_set: assert property (seq_reg_start |=> flag_q[4]) // R1
    else $error("regular start flag not set");
  a_inj_start_set: assert property (seq_inj_start |=> flag_q[3]) // R2
    else $error("injected start flag not set");
  a_inj_end_cause: assert property ($rose(flag_q[2]) |-> $past(seq_inj_done)) // R3
    else $error("injected end flag set without group end");
  a_conv_end_set: assert property ((seq_reg_done || seq_inj_done) |=> flag_q[1]) // R4
    else $error("conversion end flag not set");
  a_result_rdclr: assert property ((res_rd && !ev[1]) |=> !flag_q[1]) // R5
    else $error("result read did not clear conversion end");
  a_wd_clr_only: assert property ($fell(flag_q[0]) |-> $past(stat_clr[0])) // R6
    else $error("watchdog flag dropped without a zero write");
  a_wd_window: assert property ((conv_valid && wd_grp_ok && wd_ch_ok
    && conv_value > wd_high_q) |=> flag_q[0]) // R6
    else $error("high threshold breach not flagged");
  a_cal_reset: assert property ($rose(aresetn) |-> c_cal == ACSC_CAL_HALF) // R7
    else $error("calibration select reset wrong");
  a_reg_wd_gate: assert property ((conv_valid && !conv_injected && !c_reg_wd)
    |-> !wd_hit) // R8
    else $error("regular conversion checked while disabled");
  a_inj_wd_gate: assert property ((conv_valid && conv_injected && !c_inj_wd)
    |-> !wd_hit) // R9
    else $error("injected conversion checked while disabled");
  a_disc_count: assert property (##1 disc_channel_count == {1'b0, $past(c_dlen)} + 4'h1) // R10
    else $error("discontinuous count not code plus one");
  a_disc_write: assert property ((do_ctrl && w_strb_q[1]) |=>
    injected_discontinuous_enable == $past(w_data_q[12]) &&
    regular_discontinuous_enable == $past(w_data_q[11]) &&
    auto_injected_switch == $past(w_data_q[10])) // R11 R12 R13
    else $error("mode bits did not take written value");
  a_single_chan: assert property ((conv_valid && c_wd_sgl && conv_channel != c_wd_ch)
    |-> !wd_hit) // R15
    else $error("watchdog checked a deselected channel");
  a_resv_zero: assert property ((ar_fire && rs_ctrl) |=> (rdata & ~ACSC_CTRL_MASK) == 32'h0) // R17
    else $error("reserved control bits read nonzero");

endmodule

`default_nettype wire

// ---- acsc_pkg.sv ----
package acsc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ACSC_AW    = 8;
  localparam int ACSC_VW    = 10;
  localparam int ACSC_NFLAG = 5;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ACSC_OFF_STAT = 8'h00;
  localparam logic [7:0] ACSC_OFF_CTRL = 8'h04;
  localparam logic [7:0] ACSC_OFF_WDHI = 8'h24;
  localparam logic [7:0] ACSC_OFF_WDLO = 8'h28;
  localparam logic [7:0] ACSC_OFF_RES  = 8'h4C;
  localparam logic [7:0] ACSC_OFF_IRQ  = 8'h80;
  localparam logic [7:0] ACSC_OFF_MASK = 8'h84;

  // ----------------------------------------------------------------
  // status flag positions
  // ----------------------------------------------------------------
  localparam int ACSC_F_REG_START = 4;
  localparam int ACSC_F_INJ_START = 3;
  localparam int ACSC_F_INJ_END   = 2;
  localparam int ACSC_F_CONV_END  = 1;
  localparam int ACSC_F_WD        = 0;

  // ----------------------------------------------------------------
  // control field positions, masks, reset values
  // ----------------------------------------------------------------
  localparam int ACSC_C_CAL_LSB  = 25;
  localparam int ACSC_C_REG_WD   = 23;
  localparam int ACSC_C_INJ_WD   = 22;
  localparam int ACSC_C_DLEN_LSB = 13;
  localparam int ACSC_C_INJ_DISC = 12;
  localparam int ACSC_C_REG_DISC = 11;
  localparam int ACSC_C_AUTO     = 10;
  localparam int ACSC_C_WD_SGL   = 9;
  localparam int ACSC_C_WD_CH    = 0;

  localparam logic [31:0] ACSC_CTRL_MASK = 32'h06C0_FE1F;
  localparam logic [31:0] ACSC_CTRL_RST  = 32'h0200_0000;
  localparam logic [1:0]  ACSC_CAL_HALF  = 2'h1;
  localparam logic [1:0]  ACSC_CAL_3Q    = 2'h2;
  localparam logic [3:0]  ACSC_DCNT_RST  = 4'h1;
  localparam logic [9:0]  ACSC_THR_RST   = 10'h000;
  localparam logic [4:0]  ACSC_MASK_RST  = 5'h00;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] ACSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACSC_RESP_DECERR = 2'h3;

endpackage

// ---- acsc_sticky.sv ----
`timescale 1ns/100ps
`default_nettype none

module acsc_sticky (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // set and clear
  input  wire logic set,
  input  wire logic clr,
  // flag
  output var  logic flag_q
);

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- acsc_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module acsc_top_bench;
  import acsc_pkg::*;

  // ------------------------------
  // signals
  // ------------------------------
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, conv_valid, conv_injected;
  logic        seq_reg_start, seq_inj_start, seq_reg_done, seq_inj_done;
  logic        regular_discontinuous_enable, injected_discontinuous_enable;
  logic        auto_injected_switch, calibration_voltage_valid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0]  bresp, rresp, calibration_voltage_select;
  logic [2:0]  discontinuous_length;
  logic [3:0]  disc_channel_count, wstrb;
  logic [4:0]  conv_channel;
  logic [9:0]  conv_value, result_data;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  wire  [12:0] outs = {calibration_voltage_valid, calibration_voltage_select,
                       discontinuous_length, disc_channel_count, regular_discontinuous_enable,
                       injected_discontinuous_enable, auto_injected_switch};

  acsc_top u_acsc_top (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .seq_reg_start, .seq_inj_start,
    .seq_reg_done, .seq_inj_done, .conv_valid, .conv_injected, .conv_channel,
    .conv_value, .result_data, .calibration_voltage_select, .calibration_voltage_valid,
    .discontinuous_length, .disc_channel_count, .regular_discontinuous_enable,
    .injected_discontinuous_enable, .auto_injected_switch, .irq
  );

  always #10 aclk = ~aclk;

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic summarize;
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // valids dropped at their own handshake edge; trailing idle edge keeps
  // bready from being written twice in one time step; only the cycle guard ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd_q = rdata;
    rready <= 1'h0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, ACSC_RESP_OKAY);
    chk("rdata", e, rd_q);
  endtask

  task automatic tk;
    @(posedge aclk);
    #1;
  endtask

  task automatic oc(input logic [12:0] e);
    tk;
    chk("ctrl_out", {19'h0, e}, {19'h0, outs});
  endtask

  task automatic ev(input logic [3:0] s);
    {seq_reg_start, seq_inj_start, seq_inj_done, seq_reg_done} <= s;
    @(posedge aclk);
    {seq_reg_start, seq_inj_start, seq_inj_done, seq_reg_done} <= 4'h0;
    @(posedge aclk);
  endtask

  task automatic cv(input logic i, input logic [4:0] c, input logic [9:0] v);
    conv_valid <= 1'h1;
    conv_injected <= i;
    conv_channel <= c;
    conv_value <= v;
    @(posedge aclk);
    conv_valid <= 1'h0;
    @(posedge aclk);
  endtask

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize;
    end
  end

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, conv_valid, conv_injected} = 7'h00;
    {seq_reg_start, seq_inj_start, seq_inj_done, seq_reg_done} = 4'h0;
    {awaddr, araddr, wdata} = 48'h0;
    conv_channel = 5'h00;
    wstrb = 4'hF;
    conv_value = 10'h000;
    result_data = 10'h2A5;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rc(ACSC_OFF_CTRL, 32'h0200_0000);
    rc(ACSC_OFF_STAT, 32'h0000_0000);
    oc({1'h1, 2'h1, 3'h0, 4'h1, 3'h0});
    // one mode bit at a time: auto switch and either discontinuous mode never share a write
    wr(ACSC_OFF_CTRL, 32'hFFFF_EBFF, ACSC_RESP_OKAY);
    rc(ACSC_OFF_CTRL, 32'h06C0_EA1F);
    oc({1'h0, 2'h3, 3'h7, 4'h8, 3'h4});
    wr(ACSC_OFF_CTRL, 32'h0400_3000, ACSC_RESP_OKAY);
    oc({1'h1, 2'h2, 3'h1, 4'h2, 3'h2});
    // injected external trigger lives outside this block and is taken as off here
    wr(ACSC_OFF_CTRL, 32'h0200_0400, ACSC_RESP_OKAY);
    oc({1'h1, 2'h1, 3'h0, 4'h1, 3'h1});
    ev(4'h2);
    rc(ACSC_OFF_STAT, 32'h0000_0006);
    wr(ACSC_OFF_STAT, 32'hFFFF_FFF9, ACSC_RESP_OKAY);
    rc(ACSC_OFF_STAT, 32'h0000_0000);
    ev(4'h8);
    rc(ACSC_OFF_STAT, 32'h0000_0010);
    ev(4'h4);
    rc(ACSC_OFF_STAT, 32'h0000_0018);
    ev(4'h1);
    rc(ACSC_OFF_STAT, 32'h0000_001A);
    // zeros outside lane 0 reach no flag
    wstrb <= 4'hE;
    wr(ACSC_OFF_STAT, 32'h0000_0000, ACSC_RESP_OKAY);
    wstrb <= 4'hF;
    rc(ACSC_OFF_STAT, 32'h0000_001A);
    wr(ACSC_OFF_STAT, 32'hFFFF_FFFF, ACSC_RESP_OKAY);
    rc(ACSC_OFF_STAT, 32'h0000_001A);
    wr(ACSC_OFF_STAT, 32'hFFFF_FFEF, ACSC_RESP_OKAY);
    rc(ACSC_OFF_STAT, 32'h0000_000A);
    wr(ACSC_OFF_STAT, 32'hFFFF_FFF7, ACSC_RESP_OKAY);
    rc(ACSC_OFF_STAT, 32'h0000_0002);
    rc(ACSC_OFF_RES, 32'h0000_02A5);
    rc(ACSC_OFF_STAT, 32'h0000_0000);
    wr(ACSC_OFF_WDHI, 32'h0000_0100, ACSC_RESP_OKAY);
    wr(ACSC_OFF_WDLO, 32'h0000_0010, ACSC_RESP_OKAY);
    wr(ACSC_OFF_CTRL, 32'h0280_0000, ACSC_RESP_OKAY);
    cv(1'h0, 5'h03, 10'h050);
    rc(ACSC_OFF_STAT, 32'h0000_0000);
    cv(1'h0, 5'h03, 10'h200);
    rc(ACSC_OFF_STAT, 32'h0000_0001);
    wr(ACSC_OFF_STAT, 32'hFFFF_FFFE, ACSC_RESP_OKAY);
    cv(1'h1, 5'h03, 10'h200);
    rc(ACSC_OFF_STAT, 32'h0000_0000);
    wr(ACSC_OFF_CTRL, 32'h0240_0000, ACSC_RESP_OKAY);
    cv(1'h1, 5'h03, 10'h008);
    rc(ACSC_OFF_STAT, 32'h0000_0001);
    wr(ACSC_OFF_STAT, 32'hFFFF_FFFE, ACSC_RESP_OKAY);
    cv(1'h0, 5'h03, 10'h200);
    rc(ACSC_OFF_STAT, 32'h0000_0000);
    wr(ACSC_OFF_CTRL, 32'h02C0_0205, ACSC_RESP_OKAY);
    cv(1'h0, 5'h03, 10'h200);
    rc(ACSC_OFF_STAT, 32'h0000_0000);
    cv(1'h1, 5'h05, 10'h3FF);
    rc(ACSC_OFF_STAT, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    rd(ACSC_OFF_IRQ, ACSC_RESP_OKAY);
    wr(ACSC_OFF_MASK, 32'h0000_0001, ACSC_RESP_OKAY);
    rc(ACSC_OFF_MASK, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    cv(1'h0, 5'h05, 10'h200);
    tk;
    chk("irq", 32'h1, {31'h0, irq});
    rc(ACSC_OFF_IRQ, 32'h0000_0001);
    tk;
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h08, ACSC_RESP_DECERR);
    chk("rdata", 32'h0, rd_q);
    wr(8'h08, 32'hFFFF_FFFF, ACSC_RESP_DECERR);
    rc(ACSC_OFF_CTRL, 32'h02C0_0205);
    summarize;
  end

endmodule

`default_nettype wire
